// ==== cansw_bus_model.sv ====
// ****************************************
// Bus side: frame decoder events, pattern
// ****************************************
module cansw_bus_model (
  input  wire logic pclk,        // Clock
  output logic      frm_sof,     // Frame start
  output logic      frm_edl_vld, // EDL sampled
  output logic      frm_edl,     // EDL value
  output logic      frm_end,     // Classic frame end
  output logic      frm_ok,      // Frame correct
  output logic      frm_wuf,     // Wake frame match
  output logic      frm_eof,     // End of frame
  output logic      wup_det      // Wake pattern
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {frm_sof, frm_edl_vld, frm_edl, frm_end} = 4'h0;
    {frm_ok, frm_wuf, frm_eof, wup_det} = 4'h0;
  end

  // Qualifiers invert when idle so stale values never pass
  task automatic frame(input logic edl, input logic ok, input logic wake_frame_flag);
    frm_sof <= 1'b1;
    @(posedge pclk);
    frm_sof     <= 1'b0;
    frm_edl_vld <= 1'b1;
    frm_edl     <= edl;
    @(posedge pclk);
    frm_edl_vld <= 1'b0;
    frm_edl     <= ~edl;
    if (!edl) begin
      frm_end <= 1'b1;
      frm_ok  <= ok;
      frm_wuf <= wake_frame_flag;
      @(posedge pclk);
      frm_end <= 1'b0;
      frm_ok  <= ~ok;
      frm_wuf <= ~wake_frame_flag;
    end
    frm_eof <= 1'b1;
    @(posedge pclk);
    frm_eof <= 1'b0;
    @(posedge pclk);
  endtask : frame

  task automatic pattern;
    wup_det <= 1'b1;
    @(posedge pclk);
    wup_det <= 1'b0;
    @(posedge pclk);
  endtask : pattern
endmodule : cansw_bus_model

// ==== cansw_ctrl.sv ====
// Functional notes
// - Mode codes: off, wake, rx-only, normal, selective
// - Normal restart: off kept, plain modes become 001
// - Normal restart from selective: 101, error set
// - Other-source wake: no CAN flags, selective shows error
// - Counter overflow wakes with error, counter 100000
// - Fail-safe forces plain wake-capable mode
// - CAN wake restarts sleep, else interrupt
// - Bit timing set by host per clock
// - Receiver select picks decoder data source
// - Count transmit pulse length when measuring
// - Trim writes only when unlocked and measuring
// - Tolerant mode skips FD frames, no wake
// - EDL bit classifies FD versus classic frame
// - Decoder ready again at FD end-of-frame
// - FD filter set by host for data rate
// - Not tolerant: FD or bad counts up
// - Tolerant: only bad counts up
// - Tolerant with hold: counter held clear
// - Silence expiry clears counter hold
//
// The register offsets and the APB register port were chosen for this implementation.
module cansw_ctrl
  import cansw_pkg::*;
(
  input  wire logic        pclk,            // 50 MHz clock
  input  wire logic        presetn,         // Async reset, low
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB enable
  input  wire logic        pwrite,          // APB direction
  input  wire logic [7:0]  paddr,           // APB address
  input  wire logic [31:0] pwdata,          // APB write data
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error
  input  wire logic        restart_normal,  // Restart out of normal
  input  wire logic        sleep_entry,     // Sleep entered
  input  wire logic        other_wake,      // Non-CAN wake source
  input  wire logic        failsafe_entry,  // Fail-safe entered
  input  wire logic        frm_sof,         // Decoder saw SOF
  input  wire logic        frm_edl_vld,     // EDL bit sampled
  input  wire logic        frm_edl,         // EDL bit value
  input  wire logic        frm_end,         // Classic frame done
  input  wire logic        frm_ok,          // Frame was correct
  input  wire logic        frm_wuf,         // Frame matched wake
  input  wire logic        frm_eof,         // End-of-frame seen
  input  wire logic        wup_det,         // Bus wake pattern
  input  wire logic        bus_silent,      // Silence window open
  input  wire logic        silence_expired, // Silence time elapsed
  input  wire logic        rx_lowpower,     // Low-power receiver pin
  input  wire logic        rx_normal,       // Normal receiver pin
  input  wire logic        can_tx_input,    // Transmit pin
  output logic             dec_rx,          // Data to frame decoder
  output logic             swk_active,      // Selective wake running
  output logic      [2:0]  can_mode_sel,    // Current CAN mode
  output logic             restart_req,     // Wake from sleep
  output logic             wake_int,        // Wake in normal/stop
  output logic      [7:0]  osc_trim,        // Oscillator trim
  output logic      [5:0]  bit_timing,      // Bit timing control
  output logic      [7:0]  clock_recovery,  // Clock recovery control
  output logic      [2:0]  fd_filter        // FD dominant filter
);

  // ****************************************
  // State
  // ****************************************
  logic [2:0]       mode_q;
  logic             cfg_err_q;
  logic             wake_q;
  logic             wup_q;
  logic             wuf_q;
  logic             rxsel_q;
  logic             fd_en_q;
  logic             hold_q;
  logic [2:0]       filt_q;
  logic [5:0]       btl_q;
  logic [7:0]       cdr_q;
  logic             meas_q;
  logic [1:0]       unlock_q;
  logic [7:0]       trim_q;
  logic [OSC_W-1:0] osc_q;
  logic             sleep_q;
  logic [31:0]      prdata_q;
  logic             dec_rx_q;
  cansw_dec_t       dec_q;
  logic [1:0]       rxl_s;
  logic [1:0]       rxn_s;
  logic [1:0]       tx_s;
  logic             tx_d;

  cansw_frame_error_count_if ec ();

  cansw_frame_error_count u_frame_error_count (
    .pclk    (pclk),
    .presetn (presetn),
    .ec      (ec)
  );

  // ****************************************
  // APB decode
  // ****************************************
  logic       setup;
  logic       wr;
  logic       hit;
  logic [2:0] mode_next;
  logic       swk_sel;

  assign setup   = psel && !penable;
  assign wr      = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_q;

  always_comb begin
    unique case (paddr)
      ADDR_MODE, ADDR_WAKE, ADDR_SWK, ADDR_BTL, ADDR_CDR,
      ADDR_OSC, ADDR_OSC_H, ADDR_OSC_L, ADDR_TRIM: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Read data is captured in setup so access needs no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (setup && !pwrite) begin
      prdata_q <= '0;
      unique case (paddr)
        ADDR_MODE: begin
          prdata_q[MODE_LSB+:3]  <= mode_q;
          prdata_q[CFG_ERR_BIT]  <= cfg_err_q;
        end
        ADDR_WAKE: begin
          prdata_q[WAKE_BIT]         <= wake_q;
          prdata_q[WUP_BIT]          <= wup_q;
          prdata_q[WUF_BIT]          <= wuf_q;
          prdata_q[FRAME_ERROR_COUNT_LSB+:FRAME_ERROR_COUNT_W] <= ec.count;
        end
        ADDR_SWK: begin
          prdata_q[RXSEL_BIT]    <= rxsel_q;
          prdata_q[FDEN_BIT]     <= fd_en_q;
          prdata_q[HOLD_BIT]     <= hold_q;
          prdata_q[FILT_LSB+:3]  <= filt_q;
        end
        ADDR_BTL:   prdata_q[5:0] <= btl_q;
        ADDR_CDR:   prdata_q[7:0] <= cdr_q;
        ADDR_OSC: begin
          prdata_q[MEAS_BIT]       <= meas_q;
          prdata_q[UNLOCK_LSB+:2]  <= unlock_q;
        end
        ADDR_OSC_H: prdata_q[7:0] <= osc_q[15:8];
        ADDR_OSC_L: prdata_q[7:0] <= osc_q[7:0];
        ADDR_TRIM:  prdata_q[7:0] <= trim_q;
        default:    prdata_q <= '0;
      endcase
    end
  end

  // ****************************************
  // Mode decode and wake detection
  // ****************************************
  // Selected but failed check runs as plain wake-capable
  assign swk_sel    = mode_q[2] && (mode_q[1:0] != 2'h0);
  assign swk_active = swk_sel && !cfg_err_q;

  // Restart and sleep entry fold plain modes to 001, selective to 101
  always_comb begin
    if (mode_q[1:0] == 2'h0) begin
      mode_next = mode_q;
    end else if (mode_q[2]) begin
      mode_next = MODE_SWK;
    end else begin
      mode_next = MODE_WK;
    end
  end

  logic wk_armed;
  logic wup_wake;
  logic wuf_wake;
  logic ovf_wake;
  logic can_wake;
  logic fd_frame;
  logic good_frm;
  logic bad_frm;

  assign wk_armed = (mode_q == MODE_WK) || (swk_sel && cfg_err_q);
  assign wup_wake = wup_det && wk_armed && !wake_q;
  assign fd_frame = (dec_q == DEC_RUN) && frm_edl_vld && frm_edl;
  assign good_frm = (dec_q == DEC_RUN) && frm_end && frm_ok;
  assign bad_frm  = (dec_q == DEC_RUN) && frm_end && !frm_ok;
  // Skipped FD frames never reach here, so they cannot wake
  assign wuf_wake = good_frm && frm_wuf && swk_active && !wake_q;
  assign ovf_wake = ec.inc && ec.count == FRAME_ERROR_COUNT_MAX && swk_active
                    && sleep_q && !wake_q && !ec.clr;
  assign can_wake = wup_wake || wuf_wake || ovf_wake;

  assign restart_req = sleep_q && (can_wake || other_wake);
  assign wake_int    = !sleep_q && can_wake;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q <= 1'b0;
    end else if (restart_req) begin
      sleep_q <= 1'b0;
    end else if (sleep_entry) begin
      sleep_q <= 1'b1;
    end
  end

  // ****************************************
  // CAN mode
  // ****************************************
  // Events from the system outrank a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RST;
    end else if (failsafe_entry) begin
      mode_q <= MODE_WK;
    end else if (restart_normal || sleep_entry) begin
      mode_q <= mode_next;
    end else if (sleep_q && other_wake && swk_sel) begin
      mode_q <= MODE_SWK;
    end else if (wr && paddr == ADDR_MODE) begin
      mode_q <= pwdata[MODE_LSB+:3];
    end
  end

  assign can_mode_sel = mode_q;

  // Set beats the software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_err_q <= 1'b0;
    end else if ((restart_normal && swk_sel) || ovf_wake) begin
      cfg_err_q <= 1'b1;
    end else if (sleep_q && other_wake && swk_sel) begin
      cfg_err_q <= 1'b1;
    end else if (restart_normal) begin
      cfg_err_q <= 1'b0;
    end else if (wr && paddr == ADDR_MODE && pwdata[CFG_ERR_BIT]) begin
      cfg_err_q <= 1'b0;
    end
  end

  // ****************************************
  // Wake flags
  // ****************************************
  logic wake_clr;
  assign wake_clr = wr && paddr == ADDR_WAKE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
    end else if (can_wake) begin
      wake_q <= 1'b1;
    end else if (wake_clr && pwdata[WAKE_BIT]) begin
      wake_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wup_q <= 1'b0;
    end else if (wup_wake || (wuf_wake && !bus_silent)) begin
      wup_q <= 1'b1;
    end else if (wake_clr && pwdata[WUP_BIT]) begin
      wup_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wuf_q <= 1'b0;
    end else if (wuf_wake) begin
      wuf_q <= 1'b1;
    end else if (ovf_wake) begin
      wuf_q <= 1'b0;
    end else if (wake_clr && pwdata[WUF_BIT]) begin
      wuf_q <= 1'b0;
    end
  end

  // ****************************************
  // Frame decoder sequencing and error counter
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_q <= DEC_IDLE;
    end else begin
      unique case (dec_q)
        DEC_IDLE: if (frm_sof) dec_q <= DEC_RUN;
        DEC_RUN: begin
          if (fd_frame) begin
            dec_q <= DEC_SKIP;
          end else if (frm_end) begin
            dec_q <= DEC_IDLE;
          end
        end
        DEC_SKIP: if (frm_eof) dec_q <= DEC_IDLE;
        default:  dec_q <= DEC_IDLE;
      endcase
    end
  end

  assign ec.inc = swk_active && (bad_frm || (fd_frame && !fd_en_q));
  assign ec.dec = swk_active && (good_frm || (fd_frame && fd_en_q));
  assign ec.clr = fd_en_q && hold_q;

  // ****************************************
  // Selective wake configuration
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxsel_q <= 1'b0;
      fd_en_q <= 1'b0;
      filt_q  <= FILT_RST;
    end else if (wr && paddr == ADDR_SWK) begin
      rxsel_q <= pwdata[RXSEL_BIT];
      fd_en_q <= pwdata[FDEN_BIT];
      filt_q  <= pwdata[FILT_LSB+:3];
    end
  end

  // Expiry outranks a write landing in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 1'b0;
    end else if (silence_expired) begin
      hold_q <= 1'b0;
    end else if (wr && paddr == ADDR_SWK) begin
      hold_q <= pwdata[HOLD_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btl_q <= BTL_RST;
      cdr_q <= CDR_RST;
    end else if (wr && paddr == ADDR_BTL) begin
      btl_q <= pwdata[5:0];
    end else if (wr && paddr == ADDR_CDR) begin
      cdr_q <= pwdata[7:0];
    end
  end

  assign bit_timing     = btl_q;
  assign clock_recovery = cdr_q;
  assign fd_filter      = filt_q;

  // ****************************************
  // Pin synchronisers and receiver select
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxl_s <= 2'h3;
      rxn_s <= 2'h3;
      tx_s  <= 2'h3;
      tx_d  <= 1'b1;
    end else begin
      rxl_s <= {rxl_s[0], rx_lowpower};
      rxn_s <= {rxn_s[0], rx_normal};
      tx_s  <= {tx_s[0], can_tx_input};
      tx_d  <= tx_s[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_rx_q <= 1'b1;
    end else begin
      dec_rx_q <= rxsel_q ? rxn_s[1] : rxl_s[1];
    end
  end

  assign dec_rx = dec_rx_q;

  // ****************************************
  // Oscillator measurement and trim
  // ****************************************
  logic meas_on;
  assign meas_on = meas_q && (mode_q[1:0] == 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_q   <= 1'b0;
      unlock_q <= 2'h0;
    end else if (wr && paddr == ADDR_OSC) begin
      meas_q   <= pwdata[MEAS_BIT];
      unlock_q <= pwdata[UNLOCK_LSB+:2];
    end
  end

  // Low pulse on the transmit pin is timed; saturates rather than wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_q <= '0;
    end else if (meas_on && tx_d && !tx_s[1]) begin
      osc_q <= 16'h0001;
    end else if (meas_on && !tx_s[1] && osc_q != OSC_SAT) begin
      osc_q <= osc_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_q <= TRIM_RST;
    end else if (wr && paddr == ADDR_TRIM && unlock_q == TRIM_OPEN
                 && meas_q) begin
      trim_q <= pwdata[7:0];
    end
  end

  assign osc_trim = trim_q;

  // ****************************************
  // Checks
  // ****************************************
  a_restart_plain: assert property (@(posedge pclk) disable iff (!presetn)
    (restart_normal && !failsafe_entry && !mode_q[2]
     && mode_q[1:0] != 2'h0) |=> mode_q == MODE_WK && !cfg_err_q)
    else $error("plain mode not folded to wake-capable");

  a_restart_swk: assert property (@(posedge pclk) disable iff (!presetn)
    (restart_normal && !failsafe_entry && swk_sel)
    |=> mode_q == MODE_SWK && cfg_err_q)
    else $error("selective mode restart wrong");

  a_failsafe_mode: assert property (@(posedge pclk) disable iff (!presetn)
    failsafe_entry |=> mode_q == MODE_WK && !swk_active)
    else $error("fail-safe did not force wake-capable");

  a_trim_locked: assert property (@(posedge pclk) disable iff (!presetn)
    (unlock_q != TRIM_OPEN || !meas_q) |=> $stable(trim_q))
    else $error("trim changed while locked");

  a_silence_hold: assert property (@(posedge pclk) disable iff (!presetn)
    silence_expired |=> !hold_q)
    else $error("hold not cleared at silence expiry");

  a_skip_nowake: assert property (@(posedge pclk) disable iff (!presetn)
    (dec_q == DEC_SKIP && !ec.clr) |=> $stable(ec.count) && !$rose(wuf_q))
    else $error("skipped frame affected wake or counter");

  a_pattern_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (wup_wake && !wuf_wake) |=> wake_q && wup_q
    ##1 (wake_q || $past(wake_clr && pwdata[WAKE_BIT])))
    else $error("pattern wake flags not set");

  a_other_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_q && other_wake && !can_wake) |-> restart_req ##1
    (!sleep_q && $stable(wuf_q)))
    else $error("other wake source mishandled");

  a_ovf_error: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_wake |=> cfg_err_q && wake_q && !wuf_q && ec.count == FRAME_ERROR_COUNT_OVF)
    else $error("overflow wake state wrong");

endmodule : cansw_ctrl

// ==== cansw_frame_error_count.sv ====
module cansw_frame_error_count
  import cansw_pkg::*;
(
  input  wire logic   pclk,    // System clock
  input  wire logic   presetn, // Async reset
  cansw_frame_error_count_if.cnt   ec       // Counter control
);

  logic [FRAME_ERROR_COUNT_W-1:0] count_q;

  // ****************************************
  // Frame error counter
  // ****************************************
  // Overflow value sticks so software can read it after wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (ec.clr) begin
      count_q <= '0;
    end else if (ec.inc && count_q != FRAME_ERROR_COUNT_OVF) begin
      count_q <= count_q + 6'h01;
    end else if (ec.dec && count_q != '0 && count_q != FRAME_ERROR_COUNT_OVF) begin
      count_q <= count_q - 6'h01;
    end
  end

  assign ec.count = count_q;

  a_hold_clears: assert property (@(posedge pclk) disable iff (!presetn)
    ec.clr |=> count_q == '0)
    else $error("error counter not held clear");

  a_ovf_reach: assert property (@(posedge pclk) disable iff (!presetn)
    (ec.inc && !ec.clr && count_q == FRAME_ERROR_COUNT_MAX) |=> count_q == FRAME_ERROR_COUNT_OVF)
    else $error("counter did not reach overflow value");

endmodule : cansw_frame_error_count

// ==== cansw_frame_error_count_if.sv ====
interface cansw_frame_error_count_if;
  logic       inc;
  logic       dec;
  logic       clr;
  logic [5:0] count;
  modport ctl (output inc, output dec, output clr, input count);
  modport cnt (input inc, input dec, input clr, output count);
endinterface : cansw_frame_error_count_if

// ==== cansw_pkg.sv ====
package cansw_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_MODE   = 8'h00;
  localparam logic [7:0] ADDR_WAKE   = 8'h04;
  localparam logic [7:0] ADDR_SWK    = 8'h08;
  localparam logic [7:0] ADDR_BTL    = 8'h0C;
  localparam logic [7:0] ADDR_CDR    = 8'h10;
  localparam logic [7:0] ADDR_OSC    = 8'h14;
  localparam logic [7:0] ADDR_OSC_H  = 8'h18;
  localparam logic [7:0] ADDR_OSC_L  = 8'h1C;
  localparam logic [7:0] ADDR_TRIM   = 8'h20;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MODE_LSB     = 0;
  localparam int CFG_ERR_BIT  = 4;
  localparam int WAKE_BIT     = 0;
  localparam int WUP_BIT      = 1;
  localparam int WUF_BIT      = 2;
  localparam int FRAME_ERROR_COUNT_LSB     = 8;
  localparam int RXSEL_BIT    = 0;
  localparam int FDEN_BIT     = 1;
  localparam int HOLD_BIT     = 2;
  localparam int FILT_LSB     = 4;
  localparam int MEAS_BIT     = 0;
  localparam int UNLOCK_LSB   = 1;

  // ****************************************
  // Widths, codes and reset values
  // ****************************************
  localparam int FRAME_ERROR_COUNT_W       = 6;
  localparam int OSC_W        = 16;
  localparam logic [2:0] MODE_OFF   = 3'h0;
  localparam logic [2:0] MODE_WK    = 3'h1;
  localparam logic [2:0] MODE_SWK   = 3'h5;
  localparam logic [2:0] MODE_RST   = 3'h0;
  localparam logic [5:0] FRAME_ERROR_COUNT_MAX   = 6'h1F;
  localparam logic [5:0] FRAME_ERROR_COUNT_OVF   = 6'h20;
  localparam logic [5:0] BTL_RST    = 6'h33;
  localparam logic [7:0] CDR_RST    = 8'h00;
  localparam logic [2:0] FILT_RST   = 3'h0;
  localparam logic [7:0] TRIM_RST   = 8'h00;
  localparam logic [1:0] TRIM_OPEN  = 2'h3;
  localparam logic [15:0] OSC_SAT   = 16'hFFFF;

  typedef enum logic [1:0] {
    DEC_IDLE,
    DEC_RUN,
    DEC_SKIP
  } cansw_dec_t;

endpackage : cansw_pkg

// ==== testbench.sv ====
module testbench;
  import cansw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [4:0]  ev = 5'h00;
  logic        bus_silent = 1'b0;
  logic        rx_lowpower = 1'b1;
  logic        rx_normal = 1'b1;
  logic        can_tx_input = 1'b1;
  logic [31:0] prdata, e;
  logic        pready, pslverr, slv;
  logic        frm_sof, frm_edl_vld, frm_edl, frm_end;
  logic        frm_ok, frm_wuf, frm_eof, wup_det;
  logic        dec_rx, swk_active, restart_req, wake_int;
  logic [2:0]  can_mode_sel, fd_filter;
  logic [7:0]  osc_trim, clock_recovery;
  logic [5:0]  bit_timing;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          rq = 0;
  int          wi = 0;
  int          cnt[6] = '{1, 2, 1, 0, 1, 0};

  cansw_ctrl DUT (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .restart_normal(ev[0]),
    .sleep_entry(ev[1]), .other_wake(ev[2]), .failsafe_entry(ev[3]),
    .frm_sof, .frm_edl_vld, .frm_edl, .frm_end, .frm_ok, .frm_wuf,
    .frm_eof, .wup_det, .bus_silent, .silence_expired(ev[4]),
    .rx_lowpower, .rx_normal, .can_tx_input, .dec_rx, .swk_active,
    .can_mode_sel, .restart_req, .wake_int, .osc_trim, .bit_timing,
    .clock_recovery, .fd_filter
  );

  cansw_bus_model bus (
    .pclk, .frm_sof, .frm_edl_vld, .frm_edl, .frm_end, .frm_ok,
    .frm_wuf, .frm_eof, .wup_det
  );

  always #10 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc++;
    if (restart_req === 1'b1) rq++;
    if (wake_int === 1'b1) wi++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
      err_count++;
    end
  endtask : chk

  // ****************************************
  // APB master, held until pready
  // ****************************************
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q   = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] x);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q & m, x);
  endtask : rd

  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev <= 5'h00;
    @(posedge pclk);
  endtask : pulse

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_MODE, 32'hFF, 32'h0);
    chk({26'h0, bit_timing}, 32'h33);
    wr(ADDR_BTL, 32'h2A);
    chk({26'h0, bit_timing}, 32'h2A);
    wr(ADDR_CDR, 32'h5C);
    chk({24'h0, clock_recovery}, 32'h5C);
    rd(8'h40, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, slv}, 32'h1);
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_MODE, 32'h10 | 32'(m));
      pulse(0);
      e = (m[1:0] == 2'h0) ? 32'(m) : (m < 4) ? 32'h1 : 32'h15;
      rd(ADDR_MODE, 32'h17, e);
    end
    wr(ADDR_MODE, 32'h11);
    pulse(1);
    bus.pattern();
    rd(ADDR_WAKE, 32'h3F07, 32'h3);
    rd(ADDR_MODE, 32'h17, 32'h1);
    wr(ADDR_WAKE, 32'h7);
    wr(ADDR_MODE, 32'h17);
    pulse(1);
    bus.frame(1'b0, 1'b1, 1'b1);
    rd(ADDR_WAKE, 32'h3F07, 32'h7);
    rd(ADDR_MODE, 32'h17, 32'h5);
    wr(ADDR_WAKE, 32'h7);
    pulse(1);
    bus_silent <= 1'b1;
    bus.frame(1'b0, 1'b1, 1'b1);
    bus_silent <= 1'b0;
    rd(ADDR_WAKE, 32'h3F07, 32'h5);
    wr(ADDR_WAKE, 32'h7);
    wr(ADDR_MODE, 32'h15);
    pulse(1);
    pulse(2);
    rd(ADDR_WAKE, 32'h7, 32'h0);
    rd(ADDR_MODE, 32'h17, 32'h15);
    pulse(1);
    bus.pattern();
    rd(ADDR_WAKE, 32'h3F07, 32'h3);
    rd(ADDR_MODE, 32'h17, 32'h15);
    wr(ADDR_WAKE, 32'h7);
    wr(ADDR_MODE, 32'h15);
    pulse(1);
    repeat (32) bus.frame(1'b0, 1'b0, 1'b0);
    rd(ADDR_WAKE, 32'h3F05, 32'h2001);
    rd(ADDR_MODE, 32'h17, 32'h15);
    chk(32'(rq), 32'h6);
    wr(ADDR_SWK, 32'h56);
    chk({29'h0, fd_filter}, 32'h5);
    rd(ADDR_WAKE, 32'h3F00, 32'h0);
    pulse(4);
    rd(ADDR_SWK, 32'h77, 32'h52);
    wr(ADDR_WAKE, 32'h7);
    wr(ADDR_MODE, 32'h17);
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_SWK, (i < 3) ? 32'h4 : 32'h2);
      bus.frame(1'(6'b101001 >> i), 1'(6'b000100 >> i), 1'b0);
      rd(ADDR_WAKE, 32'h3F00, 32'(cnt[i]) << 8);
    end
    chk({31'h0, swk_active}, 32'h1);
    pulse(3);
    chk({31'h0, swk_active}, 32'h0);
    chk({29'h0, can_mode_sel}, 32'h1);
    bus.pattern();
    chk(32'(wi), 32'h1);
    wr(ADDR_SWK, 32'h1);
    rx_normal <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({31'h0, dec_rx}, 32'h0);
    wr(ADDR_SWK, 32'h0);
    repeat (4) @(posedge pclk);
    chk({31'h0, dec_rx}, 32'h1);
    wr(ADDR_MODE, 32'h10);
    wr(ADDR_OSC, 32'h1);
    can_tx_input <= 1'b0;
    repeat (50) @(posedge pclk);
    can_tx_input <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(ADDR_OSC_H, 32'hFF, 32'h0);
    rd(ADDR_OSC_L, 32'hFF, 32'h32);
    wr(ADDR_TRIM, 32'hA5);
    chk({24'h0, osc_trim}, 32'h0);
    wr(ADDR_OSC, 32'h7);
    wr(ADDR_TRIM, 32'hA5);
    chk({24'h0, osc_trim}, 32'hA5);
    wr(ADDR_OSC, 32'h1);
    wr(ADDR_TRIM, 32'h5A);
    chk({24'h0, osc_trim}, 32'hA5);
    print_verdict();
  end
endmodule : testbench
